//--- design/pmic_fault_interrupt_regs.sv
// Fault interrupt sense, latched status and mask registers behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
module pmic_fault_interrupt_regs (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire pmic_irq_pkg::cond_t cond_in,
   input wire logic [pmic_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pmic_irq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq_out_n
);
   import pmic_irq_pkg::*;

   // ----------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;
   cond_t cond_meta_r;
   cond_t cond_r;
   cond_t cond_prev_r;

   // Release of reset is synchronised, assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Detector outputs are asynchronous levels; only cond_r and cond_prev_r are used by logic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_meta_r <= '0;
         cond_r <= '0;
         cond_prev_r <= '0;
      end else begin
         cond_meta_r <= cond_in;
         cond_r <= cond_meta_r;
         cond_prev_r <= cond_r;
      end
   end

   // ----------------------------------------------------------------
   // Live sense words
   // ----------------------------------------------------------------
   wire logic [7:0] sense0_w;
   wire logic [7:0] buck_sense_w;
   wire logic [7:0] ov_sense_w;
   wire logic [7:0] ldo_sense_w;
   wire logic [7:0] buck_rise_w;
   wire logic [7:0] ov_rise_w;
   wire logic [7:0] ldo_rise_w;

   // Sense words are combinational from the synchronised levels, never latched
   assign sense0_w = {cond_r.test_mode_pin, 1'b0, cond_r.temp_hi,
                      cond_r.input_undervolt, cond_r.power_button_pin};
   assign buck_sense_w = {3'b000, cond_r.buck_ilim[2], cond_r.buck_ilim[1],
                          2'b00, cond_r.buck_ilim[0]};
   assign ov_sense_w = {5'b00000, cond_r.frontend_overvolt, 2'b00};
   assign ldo_sense_w = {2'b00, cond_r.ldo_ilim};

   // Entry into a fault is the rising edge of its level; a fault present at
   // power-on also counts as an entry because the history starts at zero
   assign buck_rise_w = buck_sense_w & ~{3'b000, cond_prev_r.buck_ilim[2],
                        cond_prev_r.buck_ilim[1], 2'b00, cond_prev_r.buck_ilim[0]};
   assign ov_rise_w = ov_sense_w & ~{5'b00000, cond_prev_r.frontend_overvolt, 2'b00};
   assign ldo_rise_w = ldo_sense_w & ~{2'b00, cond_prev_r.ldo_ilim};

   // ----------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------
   // Tells whether an index is a mapped register
   function automatic logic is_mapped(input logic [5:0] idx);
      case (idx)
         IDX_LIVE_SENSE0, IDX_BUCK_STATUS, IDX_BUCK_MASK, IDX_BUCK_SENSE,
         IDX_OV_STATUS, IDX_OV_MASK, IDX_OV_SENSE,
         IDX_LDO_STATUS, IDX_LDO_MASK, IDX_LDO_SENSE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane0_r;
   logic aw_held_r;
   logic w_held_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] buck_st_r;
   logic [7:0] buck_mask_r;
   logic [7:0] ov_st_r;
   logic [7:0] ov_mask_r;
   logic [7:0] ldo_st_r;
   logic [7:0] ldo_mask_r;
   logic irq_r;

   wire logic [5:0] aw_idx_w;
   wire logic [5:0] ar_idx_w;
   wire logic wr_do_w;
   wire logic wr_ok_w;
   wire logic [7:0] wr_byte_w;
   wire logic ar_take_w;
   wire logic [7:0] rd_byte_w;

   assign aw_idx_w = aw_addr_r[ADDR_LSB +: 6];
   assign ar_idx_w = s_axi_araddr[ADDR_LSB +: 6];
   // A write is done once address and data are both held
   assign wr_do_w = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_ok_w = wr_do_w & w_lane0_r;
   assign wr_byte_w = w_data_r;
   assign ar_take_w = s_axi_arvalid & s_axi_arready;

   // Read selection; unimplemented bits are already zero in each word
   assign rd_byte_w = (ar_idx_w == IDX_LIVE_SENSE0) ? (sense0_w & SENSE0_BITS) :
                      (ar_idx_w == IDX_BUCK_STATUS) ? buck_st_r :
                      (ar_idx_w == IDX_BUCK_MASK) ? buck_mask_r :
                      (ar_idx_w == IDX_BUCK_SENSE) ? buck_sense_w :
                      (ar_idx_w == IDX_OV_STATUS) ? ov_st_r :
                      (ar_idx_w == IDX_OV_MASK) ? ov_mask_r :
                      (ar_idx_w == IDX_OV_SENSE) ? ov_sense_w :
                      (ar_idx_w == IDX_LDO_STATUS) ? ldo_st_r :
                      (ar_idx_w == IDX_LDO_MASK) ? ldo_mask_r :
                      (ar_idx_w == IDX_LDO_SENSE) ? ldo_sense_w : 8'h00;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data are taken in either order; no new ones while a
   // response is pending, which keeps one write in flight
   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 8'h00;
         w_lane0_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_do_w) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
         end else if (wr_do_w) begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Response: SLVERR for an unmapped index, OKAY otherwise
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_do_w) begin
         bvalid_r <= 1'b1;
         bresp_r <= is_mapped(aw_idx_w) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Read data is captured at the address handshake; reads have no side effect
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ar_take_w) begin
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rd_byte_w};
         rresp_r <= is_mapped(ar_idx_w) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Status flags and masks
   // ----------------------------------------------------------------
   wire logic [7:0] buck_clr_w;
   wire logic [7:0] ov_clr_w;
   wire logic [7:0] ldo_clr_w;
   wire logic [7:0] buck_st_nxt;
   wire logic [7:0] ov_st_nxt;
   wire logic [7:0] ldo_st_nxt;
   wire logic any_pend_w;

   // Writing one clears, zero leaves alone; a new fault in the same cycle wins
   assign buck_clr_w = (wr_ok_w && aw_idx_w == IDX_BUCK_STATUS) ? wr_byte_w : 8'h00;
   assign ov_clr_w = (wr_ok_w && aw_idx_w == IDX_OV_STATUS) ? wr_byte_w : 8'h00;
   assign ldo_clr_w = (wr_ok_w && aw_idx_w == IDX_LDO_STATUS) ? wr_byte_w : 8'h00;
   assign buck_st_nxt = ((buck_st_r & ~buck_clr_w) | buck_rise_w) & BUCK_BITS;
   assign ov_st_nxt = ((ov_st_r & ~ov_clr_w) | ov_rise_w) & OV_BITS;
   assign ldo_st_nxt = ((ldo_st_r & ~ldo_clr_w) | ldo_rise_w) & LDO_BITS;

   // A flag reaches the pin only while its mask bit is zero
   assign any_pend_w = |(buck_st_r & ~buck_mask_r) | |(ov_st_r & ~ov_mask_r)
                     | |(ldo_st_r & ~ldo_mask_r);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_st_r <= STATUS_RESET;
         ov_st_r <= STATUS_RESET;
         ldo_st_r <= STATUS_RESET;
      end else begin
         buck_st_r <= buck_st_nxt;
         ov_st_r <= ov_st_nxt;
         ldo_st_r <= ldo_st_nxt;
      end
   end

   // Masks keep only implemented positions so reserved bits read zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_mask_r <= MASK_RESET & BUCK_BITS;
         ov_mask_r <= MASK_RESET & OV_BITS;
         ldo_mask_r <= MASK_RESET & LDO_BITS;
      end else if (wr_ok_w) begin
         if (aw_idx_w == IDX_BUCK_MASK) buck_mask_r <= wr_byte_w & BUCK_BITS;
         if (aw_idx_w == IDX_OV_MASK) ov_mask_r <= wr_byte_w & OV_BITS;
         if (aw_idx_w == IDX_LDO_MASK) ldo_mask_r <= wr_byte_w & LDO_BITS;
      end
   end

   // Registered pin drive avoids glitches on the host's interrupt line
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= any_pend_w;
      end
   end
   assign irq_out_n = ~irq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [5:0] rd_idx_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_idx_r <= 6'h00;
      end else if (ar_take_w) begin
         rd_idx_r <= ar_idx_w;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_sense0_live: assert property (
      ar_take_w && ar_idx_w == IDX_LIVE_SENSE0 |=> s_axi_rdata[7:0] == $past(sense0_w))
      else $error("sense0 read does not show live levels");
   chk_sense0_fields: assert property (
      s_axi_rvalid && rd_idx_r == IDX_LIVE_SENSE0 && $rose(s_axi_rvalid)
      |-> s_axi_rdata[POS_TEST] == $past(cond_r.test_mode_pin)
       && s_axi_rdata[POS_PBTN] == $past(cond_r.power_button_pin)
       && s_axi_rdata[POS_UV] == $past(cond_r.input_undervolt)
       && s_axi_rdata[POS_TEMP_LO +: 4] == $past(cond_r.temp_hi))
      else $error("sense0 field placement wrong");
   chk_unused_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000
       && !(rd_idx_r == IDX_LIVE_SENSE0 && s_axi_rdata[POS_UNUSED6]))
      else $error("reserved read bits not zero");
   chk_buck_set: assert property (
      $rose(cond_r.buck_ilim[2]) |=> buck_st_r[POS_BUCK3]
      ##1 (buck_st_r[POS_BUCK3] || $past(buck_clr_w[POS_BUCK3])))
      else $error("buck three flag not set on limit entry");
   chk_w1c_zero: assert property (
      wr_ok_w && aw_idx_w == IDX_BUCK_STATUS && wr_byte_w == 8'h00
      |=> (buck_st_r & $past(buck_st_r)) == $past(buck_st_r))
      else $error("writing zero changed a flag");
   chk_w1c_clear: assert property (
      wr_ok_w && aw_idx_w == IDX_OV_STATUS && wr_byte_w[POS_OV] && !ov_rise_w[POS_OV]
      |=> !ov_st_r[POS_OV])
      else $error("writing one did not clear the flag");
   chk_irq_follow: assert property (
      any_pend_w |=> !irq_out_n)
      else $error("unmasked flag not on pin");
   chk_irq_release: assert property (
      !any_pend_w [*2] |-> ##1 irq_out_n)
      else $error("pin held with nothing pending");
   chk_mask_gate: assert property (
      buck_mask_r == BUCK_BITS && ov_mask_r == OV_BITS && ldo_mask_r == LDO_BITS |=> irq_out_n)
      else $error("masked flags reached the pin");
   chk_ov_sense: assert property (
      ar_take_w && ar_idx_w == IDX_OV_SENSE
      |=> s_axi_rdata[POS_OV] == $past(cond_r.frontend_overvolt)
       && (s_axi_rdata[7:0] & ~OV_BITS) == 8'h00)
      else $error("overvoltage sense wrong");
   chk_ldo_set: assert property (
      $rose(cond_r.ldo_ilim[0]) |=> ldo_st_r[0])
      else $error("linreg1 flag not set");
   chk_buck_sense: assert property (
      ar_take_w && ar_idx_w == IDX_BUCK_SENSE
      |=> s_axi_rdata[POS_BUCK2] == $past(cond_r.buck_ilim[1])
       && s_axi_rdata[POS_BUCK1] == $past(cond_r.buck_ilim[0]))
      else $error("buck sense read wrong");
   // Buck one and overvoltage flags latch on entry just like the buck three one; a one clears linreg1
   chk_buck1_set: assert property (
      $rose(cond_r.buck_ilim[0]) |=> buck_st_r[POS_BUCK1])
      else $error("buck one flag not set on limit entry");
   chk_ov_set: assert property (
      $rose(cond_r.frontend_overvolt) |=> ov_st_r[POS_OV])
      else $error("overvoltage flag not set on entry");
   chk_ldo_clear: assert property (
      wr_ok_w && aw_idx_w == IDX_LDO_STATUS && wr_byte_w[0] && !ldo_rise_w[0]
      |=> !ldo_st_r[0])
      else $error("linreg1 flag not cleared by a one");
   // Reserved mask bits must stay zero whatever was written
   chk_mask_reserved: assert property (
      ar_take_w && ar_idx_w == IDX_BUCK_MASK
      |=> (s_axi_rdata[7:0] & ~BUCK_BITS) == 8'h00)
      else $error("reserved mask bits read nonzero");
   chk_unmapped_err: assert property (
      wr_do_w && !is_mapped(aw_idx_w) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   // A write whose byte 0 strobe is off is answered but must not land
   chk_strb_ignored: assert property (
      wr_do_w && !w_lane0_r && aw_idx_w == IDX_BUCK_MASK
      |=> buck_mask_r == $past(buck_mask_r))
      else $error("write without byte 0 strobe changed a mask");
   chk_ldo_sense: assert property (
      ar_take_w && ar_idx_w == IDX_LDO_SENSE
      |=> s_axi_rdata[7:0] == {2'b00, $past(cond_r.ldo_ilim)})
      else $error("linear regulator sense read wrong");
endmodule
`default_nettype wire

//--- design/pmic_irq_pkg.sv
// Package: register map, field layouts and condition carrier for the fault interrupt block
package pmic_irq_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [5:0] IDX_LIVE_SENSE0 = 6'h07;
   localparam logic [5:0] IDX_BUCK_STATUS = 6'h08;
   localparam logic [5:0] IDX_BUCK_MASK = 6'h09;
   localparam logic [5:0] IDX_BUCK_SENSE = 6'h0A;
   localparam logic [5:0] IDX_OV_STATUS = 6'h0E;
   localparam logic [5:0] IDX_OV_MASK = 6'h0F;
   localparam logic [5:0] IDX_OV_SENSE = 6'h10;
   localparam logic [5:0] IDX_LDO_STATUS = 6'h11;
   localparam logic [5:0] IDX_LDO_MASK = 6'h12;
   localparam logic [5:0] IDX_LDO_SENSE = 6'h13;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 8;

   // Implemented bit positions of each group
   localparam logic [7:0] SENSE0_BITS = 8'hBF;
   localparam logic [7:0] BUCK_BITS = 8'h19;
   localparam logic [7:0] OV_BITS = 8'h04;
   localparam logic [7:0] LDO_BITS = 8'h3F;

   // Field positions
   localparam int POS_TEST = 7;
   localparam int POS_UNUSED6 = 6;
   localparam int POS_TEMP_LO = 2;
   localparam int POS_UV = 1;
   localparam int POS_PBTN = 0;
   localparam int POS_BUCK1 = 0;
   localparam int POS_BUCK2 = 3;
   localparam int POS_BUCK3 = 4;
   localparam int POS_OV = 2;

   // Reset values: masks come up masked, flags clear
   localparam logic [7:0] MASK_RESET = 8'hFF;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Live conditions from the analog detectors and pins
   typedef struct packed {
      logic test_mode_pin;
      logic [3:0] temp_hi;    // [3]=130, [2]=125, [1]=120, [0]=110 degrees
      logic input_undervolt;
      logic power_button_pin;
      logic [2:0] buck_ilim;  // [2]=buck three .. [0]=buck one
      logic frontend_overvolt;
      logic [5:0] ldo_ilim;   // linreg4, linreg3, 3.3 V, card, linreg2, linreg1
   } cond_t;
endpackage

//--- dv/host_cpu_model.sv
// Host processor model: AXI4-Lite master that reads and writes the fault registers
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
   input wire logic ref_clk,
   output logic [pmic_irq_pkg::ADDR_W-1:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [pmic_irq_pkg::ADDR_W-1:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   import pmic_irq_pkg::*;
   // Loop cycle count that must be reached before bready or rready rises, to play a slow host
   int lag;
   // Write strobes offered, so a write with byte 0 switched off can be tried
   logic [3:0] strb;
   initial begin
      lag = 0;
      strb = 4'hF;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // Handshakes are judged at the falling edge, where every signal is settled
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
      logic a_ok;
      logic w_ok;
      logic b_ok;
      int n;
      n = 0;
      b_ok = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b_ok) begin
         @(negedge ref_clk);
         a_ok = awvalid & awready;
         w_ok = wvalid & wready;
         b_ok = bvalid & bready;
         resp = bresp;
         @(posedge ref_clk);
         n++;
         if (a_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         if (n >= lag) bready <= !b_ok;
      end
      // Released lines show the inverse so stale values cannot pass; one idle
      // edge follows so a back-to-back call never drives a line twice at once
      awaddr <= ~awaddr;
      wdata <= ~wdata;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
      logic a_ok;
      logic r_ok;
      int n;
      n = 0;
      r_ok = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      while (!r_ok) begin
         @(negedge ref_clk);
         a_ok = arvalid & arready;
         r_ok = rvalid & rready;
         d = rdata;
         resp = rresp;
         @(posedge ref_clk);
         n++;
         if (a_ok) arvalid <= 1'b0;
         if (n >= lag) rready <= !r_ok;
      end
      araddr <= ~araddr;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking testbench for the fault interrupt register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pmic_irq_pkg::*;
   localparam int CW = $bits(cond_t);
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   cond_t cond_in = '0;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq_out_n;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   int err_total = 0;
   int n_checks = 0;
   always #25 ref_clk = ~ref_clk;
   pmic_fault_interrupt_regs pmic_fault_interrupt_regs_i (
      .ref_clk(ref_clk), .resetn(resetn), .cond_in(cond_in),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq_out_n(irq_out_n));
   host_cpu_model host_cpu_model_i (
      .ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // ----------------------------------------
   // Helpers and expected-value functions
   // ----------------------------------------
   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
      host_cpu_model_i.rd(idx, got, resp);
      chk(nm, got, {24'h0, exp});
      chk("rresp", 32'(resp), 32'(RESP_OKAY));
   endtask
   // Pin is looked at mid-cycle, clear of the edge that moves it
   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("irq_out_n", 32'(irq_out_n), 32'(exp));
      @(posedge ref_clk);
   endtask
   function automatic logic [7:0] sense0_of(cond_t c);
      return {c.test_mode_pin, 1'b0, c.temp_hi, c.input_undervolt, c.power_button_pin};
   endfunction
   function automatic logic [7:0] buck_of(logic [2:0] b);
      return {3'h0, b[2], b[1], 2'h0, b[0]};
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(31564));
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge ref_clk);
      // Masks come up masked, flags clear, pin released
      rchk("buck status", IDX_BUCK_STATUS, 8'h00);
      rchk("buck mask", IDX_BUCK_MASK, MASK_RESET & BUCK_BITS);
      rchk("ov status", IDX_OV_STATUS, 8'h00);
      rchk("ov mask", IDX_OV_MASK, MASK_RESET & OV_BITS);
      rchk("ldo status", IDX_LDO_STATUS, 8'h00);
      irq_chk(1'b1);
      host_cpu_model_i.wr(6'h3F, 8'hFF, resp);
      chk("bresp", 32'(resp), 32'(RESP_SLVERR));
      host_cpu_model_i.rd(6'h3F, got, resp);
      chk("rresp", 32'(resp), 32'(RESP_SLVERR));
      // Live levels, random and corner patterns, with a slow host now and then
      for (int i = 0; i < 24; i++) begin
         cond_in <= (i == 0) ? cond_t'('1) : (i == 1) ? cond_t'('0) : cond_t'(CW'($urandom));
         host_cpu_model_i.lag = i % 3;
         host_cpu_model_i.wr(IDX_LIVE_SENSE0, 8'hFF, resp);
         chk("sense0 bresp", 32'(resp), 32'(RESP_OKAY));
         repeat (3) @(posedge ref_clk);
         rchk("sense0", IDX_LIVE_SENSE0, sense0_of(cond_in));
         rchk("buck sense", IDX_BUCK_SENSE, buck_of(cond_in.buck_ilim));
         rchk("ov sense", IDX_OV_SENSE, {5'h0, cond_in.frontend_overvolt, 2'h0});
         rchk("ldo sense", IDX_LDO_SENSE, {2'h0, cond_in.ldo_ilim});
      end
      host_cpu_model_i.lag = 0;
      // A write with byte lane 0 switched off is answered but changes nothing
      host_cpu_model_i.strb = 4'hE;
      host_cpu_model_i.wr(IDX_BUCK_MASK, 8'h00, resp);
      host_cpu_model_i.strb = 4'hF;
      chk("strb bresp", 32'(resp), 32'(RESP_OKAY));
      rchk("mask kept", IDX_BUCK_MASK, MASK_RESET & BUCK_BITS);
      cond_in <= '0;
      repeat (4) @(posedge ref_clk);
      host_cpu_model_i.wr(IDX_BUCK_STATUS, 8'hFF, resp);
      host_cpu_model_i.wr(IDX_OV_STATUS, 8'hFF, resp);
      host_cpu_model_i.wr(IDX_LDO_STATUS, 8'hFF, resp);
      // Each flag: latch, survive a zero write, reach the pin only when unmasked
      for (int k = 0; k < 10; k++) begin
         cond_t c;
         logic [5:0] s;
         logic [7:0] b;
         logic [7:0] g;
         c = '0;
         s = (k < 3) ? IDX_BUCK_STATUS : (k == 3) ? IDX_OV_STATUS : IDX_LDO_STATUS;
         g = (k < 3) ? BUCK_BITS : (k == 3) ? OV_BITS : LDO_BITS;
         b = (k < 3) ? buck_of(3'h1 << k) : (k == 3) ? 8'h04 : 8'h01 << (k - 4);
         if (k < 3) c.buck_ilim[k] = 1'b1;
         else if (k == 3) c.frontend_overvolt = 1'b1;
         else c.ldo_ilim[k-4] = 1'b1;
         cond_in <= c;
         repeat (4) @(posedge ref_clk);
         cond_in <= '0;
         repeat (4) @(posedge ref_clk);
         rchk("flag set", s, b);
         host_cpu_model_i.wr(s, ~b, resp);
         chk("bresp", 32'(resp), 32'(RESP_OKAY));
         rchk("flag kept", s, b);
         irq_chk(1'b1);
         host_cpu_model_i.wr(s + 6'h1, ~b, resp);
         rchk("mask", s + 6'h1, g & ~b);
         irq_chk(1'b0);
         host_cpu_model_i.wr(s, b, resp);
         rchk("flag cleared", s, 8'h00);
         irq_chk(1'b1);
         host_cpu_model_i.wr(s + 6'h1, 8'hFF, resp);
      end
      end_of_test();
   end
   // Watchdog: the sequence needs a few thousand cycles at most
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_total++;
      end_of_test();
   end
endmodule
`default_nettype wire
